// file: verilog/power_down_defines.svh
// constants for the power-down mode controller
// Overview of operation
// - reset loads control register A with 0x07.
// - standby select 0: sleep goes active to sleep, subactive to subsleep.
// - standby select 1: sleep goes active to standby/watch, subactive to watch.
// - settling code gives 8192..65536 states, top bit set gives 131072.
// - leaving standby/watch for active by interrupt applies the settling wait.
// - on leaving watch, low speed select picks system clock or subclock.
// - register A bit 2 reads 1 and ignores writes.
// - medium divider picks oscillator /16, /32, /64 or /128.
// - register B resets to 0xE0, top three bits read 1.
// - noise filter select samples watch clock at osc/16 or osc/4.
// - direct transfer off: sleep enters standby, watch, sleep or subsleep.
// - direct transfer from high-speed goes to medium-speed or subactive.
// - direct transfer from medium-speed goes to high-speed or subactive.
// - direct transfer from subactive goes to high- or medium-speed.
// - medium speed select picks speed after wake and for direct transfer.
// - subactive divider picks watch clock /8, /4 or /2.
// - subactive divider writes are ignored while in subactive mode.
// - standby select 1, low speed 0: timer bit 0 standby, 1 watch.
`ifndef POWER_DOWN_DEFINES_SVH
`define POWER_DOWN_DEFINES_SVH
`define PDM_ADDR_CTRL_A 12'h000
`define PDM_ADDR_CTRL_B 12'h004
`define PDM_ADDR_STATUS 12'h008
`define PDM_ADDR_TIMER 12'h00C
`define PDM_CTRL_A_RESET 8'h07
`define PDM_CTRL_B_RESET 8'hE0
`define PDM_CTRL_A_FIXED 8'h04
`define PDM_CTRL_B_FIXED 8'hE0
`define PDM_A_STBY 7
`define PDM_A_WAIT_HI 6
`define PDM_A_WAIT_LO 4
`define PDM_A_LOWSPD 3
`define PDM_A_MDIV_HI 1
`define PDM_B_NOISE 4
`define PDM_B_DIRECT 3
`define PDM_B_MEDSPD 2
`define PDM_B_SDIV_HI 1
`define PDM_WAIT_0 18'd8192
`define PDM_WAIT_1 18'd16384
`define PDM_WAIT_2 18'd32768
`define PDM_WAIT_3 18'd65536
`define PDM_WAIT_4 18'd131072
`endif

// file: verilog/power_down_pkg.sv
// types for the power-down mode controller
`default_nettype none
package power_down_pkg;
	typedef enum logic [7:0] {
		MODE_ACT_HIGH = 8'h01,
		MODE_ACT_MED = 8'h02,
		MODE_SUBACT = 8'h04,
		MODE_SLEEP = 8'h08,
		MODE_SUBSLEEP = 8'h10,
		MODE_STANDBY = 8'h20,
		MODE_WATCH = 8'h40,
		MODE_SETTLE = 8'h80
	} power_mode_t;
endpackage
`default_nettype wire

// file: verilog/settle_if.sv
// start/done link between the mode controller and the settling timer
`default_nettype none
interface settle_if;
	logic start;
	logic [2:0] code;
	logic done;
	modport ctrl (output start, output code, input done);
	modport timer (input start, input code, output done);
endinterface
`default_nettype wire

// file: verilog/settle_timer.sv
// oscillator settling wait counter
`include "power_down_defines.svh"
`default_nettype none
module settle_timer #(
	parameter int SCALE = 1
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	settle_if.timer link,
	output logic [17:0] count_out
);
	logic [17:0] count;
	logic running;
	logic [17:0] limit;
	logic [17:0] scaled;
	assign limit = link.code[2] ? `PDM_WAIT_4 :
		(link.code[1:0] == 2'b11) ? `PDM_WAIT_3 :
		(link.code[1:0] == 2'b10) ? `PDM_WAIT_2 :
		(link.code[1:0] == 2'b01) ? `PDM_WAIT_1 : `PDM_WAIT_0;
	assign scaled = (limit / 18'(SCALE) == 18'd0) ? 18'd1 : limit / 18'(SCALE);
	assign link.done = running && (count == scaled - 18'd1);
	assign count_out = count;
	always_ff @(posedge mclk_in) begin
		if (rst_in || link.done) begin
			running <= 1'b0;
			count <= 18'd0;
		end else if (link.start) begin
			running <= 1'b1;
			count <= 18'd0;
		end else if (running) begin
			count <= count + 18'd1;
		end
	end
endmodule // settle_timer
`default_nettype wire

// file: verilog/clock_divider.sv
// programmable clock-enable pulse generator
`default_nettype none
module clock_divider #(
	parameter int WIDTH = 7
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] terminal_in,
	output logic tick_out
);
	logic [WIDTH-1:0] count;
	logic wrap;
	assign wrap = (count >= terminal_in);
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			count <= '0;
			tick_out <= 1'b0;
		end else begin
			count <= wrap ? '0 : count + 1'b1;
			tick_out <= wrap;
		end
	end
endmodule // clock_divider
`default_nettype wire

// file: verilog/power_down_ctrl.sv
// power-down mode controller with APB registers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`include "power_down_defines.svh"
`default_nettype none
module power_down_ctrl
	import power_down_pkg::*;
#(
	parameter int SETTLE_SCALE = 1
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_in,
	input wire logic wake_in,
	input wire logic timer_a_clock_mode_bit_in,
	output logic [7:0] mode_out,
	output logic cpu_run_out,
	output logic osc_run_out,
	output logic use_subclock_out,
	output logic med_tick_out,
	output logic noise_tick_out,
	output logic [1:0] sub_div_sel_out
);
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	power_mode_t mode;
	power_mode_t next_mode;
	power_mode_t settle_target;
	power_mode_t next_settle_target;
	logic [17:0] settle_count;
	logic [31:0] next_prdata;
	logic rd_ready;
	settle_if settle ();

	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd_access = access && !pwrite;
	wire hit_a = (paddr == `PDM_ADDR_CTRL_A);
	wire hit_b = (paddr == `PDM_ADDR_CTRL_B);
	wire hit_s = (paddr == `PDM_ADDR_STATUS);
	wire hit_t = (paddr == `PDM_ADDR_TIMER);
	wire mapped = hit_a || hit_b || hit_s || hit_t;
	wire wr_a = wr && hit_a;
	wire wr_b = wr && hit_b;

	wire stby = ctrl_a[`PDM_A_STBY];
	wire lowspd = ctrl_a[`PDM_A_LOWSPD];
	wire direct = ctrl_b[`PDM_B_DIRECT];
	wire medspd = ctrl_b[`PDM_B_MEDSPD];
	wire tbit = timer_a_clock_mode_bit_in;
	wire in_active = (mode == MODE_ACT_HIGH) || (mode == MODE_ACT_MED);
	wire in_sub = (mode == MODE_SUBACT);
	// wake speed after standby, watch or sleep
	wire power_mode_t wake_speed = medspd ? MODE_ACT_MED : MODE_ACT_HIGH;

	// reads take one wait state so registered read data stands when pready rises
	assign pready = !rd_access || rd_ready;
	assign pslverr = access && !mapped;

	wire [7:0] new_a = pwdata[7:0] | `PDM_CTRL_A_FIXED;
	wire [1:0] new_sdiv = in_sub ? ctrl_b[`PDM_B_SDIV_HI:0] : pwdata[1:0];
	// top three bits fixed at 1
	wire [7:0] new_b = {3'b111, pwdata[4:2], new_sdiv};

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ctrl_a <= `PDM_CTRL_A_RESET;
			ctrl_b <= `PDM_CTRL_B_RESET;
		end else begin
			if (wr_a) begin
				ctrl_a <= new_a;
			end
			if (wr_b) begin
				ctrl_b <= new_b;
			end
		end
	end

	assign next_prdata = !(rd_access && !rd_ready) ? prdata :
		hit_a ? {24'h0, ctrl_a} :
		hit_b ? {24'h0, ctrl_b} :
		hit_s ? {24'h0, mode} :
		hit_t ? {14'h0, settle_count} : 32'h0;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			prdata <= 32'h0;
			rd_ready <= 1'b0;
		end else begin
			prdata <= next_prdata;
			rd_ready <= rd_access && !rd_ready;
		end
	end

	always_comb begin
		next_mode = mode;
		next_settle_target = settle_target;
		settle.start = 1'b0;
		case (mode)
			MODE_ACT_HIGH, MODE_ACT_MED: begin
				if (sleep_in) begin
					if (direct) begin
						if (mode == MODE_ACT_HIGH && !stby && medspd && !lowspd) begin
							next_mode = MODE_ACT_MED;
						end else if (mode == MODE_ACT_MED && !stby && !medspd && !lowspd) begin
							next_mode = MODE_ACT_HIGH;
						end else if (stby && tbit && lowspd) begin
							next_mode = MODE_SUBACT;
						end
					end else if (!stby && !lowspd) begin
						next_mode = MODE_SLEEP;
					end else if (stby) begin
						// timer bit picks standby or watch
						if (tbit) begin
							next_mode = MODE_WATCH;
						end else if (!lowspd) begin
							next_mode = MODE_STANDBY;
						end
					end
				end
			end
			MODE_SUBACT: begin
				if (sleep_in) begin
					if (direct) begin
						if (stby && tbit && !lowspd) begin
							next_mode = wake_speed;
						end
					end else if (stby && tbit) begin
						next_mode = MODE_WATCH;
					end else if (!stby && lowspd && tbit) begin
						next_mode = MODE_SUBSLEEP;
					end
				end
			end
			MODE_SLEEP: begin
				if (wake_in) begin
					next_mode = wake_speed;
				end
			end
			MODE_SUBSLEEP: begin
				if (wake_in) begin
					next_mode = MODE_SUBACT;
				end
			end
			MODE_STANDBY, MODE_WATCH: begin
				if (wake_in) begin
					// low speed picks subclock on watch exit
					if (mode == MODE_WATCH && lowspd) begin
						next_mode = MODE_SUBACT;
					end else begin
						settle.start = 1'b1;
						next_settle_target = wake_speed;
						next_mode = MODE_SETTLE;
					end
				end
			end
			MODE_SETTLE: begin
				if (settle.done) begin
					next_mode = settle_target;
				end
			end
			default: begin
				next_mode = MODE_ACT_HIGH;
			end
		endcase
	end

	assign settle.code = ctrl_a[`PDM_A_WAIT_HI:`PDM_A_WAIT_LO];

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mode <= MODE_ACT_HIGH;
			settle_target <= MODE_ACT_HIGH;
		end else begin
			mode <= next_mode;
			settle_target <= next_settle_target;
		end
	end

	settle_timer #(
		.SCALE(SETTLE_SCALE)
	) u_settle (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.link(settle),
		.count_out(settle_count)
	);

	wire [6:0] med_term = 7'((8'h10 << ctrl_a[`PDM_A_MDIV_HI:0]) - 8'h01);
	clock_divider #(
		.WIDTH(7)
	) u_med (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.terminal_in(med_term),
		.tick_out(med_tick_out)
	);

	// noise filter sampling osc/16 or osc/4
	wire [6:0] noise_term = ctrl_b[`PDM_B_NOISE] ? 7'h03 : 7'h0F;
	clock_divider #(
		.WIDTH(7)
	) u_noise (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.terminal_in(noise_term),
		.tick_out(noise_tick_out)
	);

	assign mode_out = mode;
	assign cpu_run_out = in_active || in_sub;
	assign osc_run_out = !(mode == MODE_STANDBY || mode == MODE_WATCH
		|| mode == MODE_SUBACT || mode == MODE_SUBSLEEP);
	assign use_subclock_out = in_sub || (mode == MODE_SUBSLEEP);
	// 00 /8, 01 /4, 1x /2
	assign sub_div_sel_out = ctrl_b[`PDM_B_SDIV_HI] ? 2'b10 : {1'b0, ctrl_b[0]};
endmodule // power_down_ctrl
`default_nettype wire

// file: verification/power_down_ctrl_sva.sv
// port assertions for the power-down mode controller
`default_nettype none
module power_down_ctrl_sva #(
	parameter int SETTLE_SCALE = 1
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic wake_in,
	input wire logic [7:0] mode_out,
	input wire logic cpu_run_out,
	input wire logic use_subclock_out,
	input wire logic med_tick_out,
	input wire logic noise_tick_out,
	input wire logic [1:0] sub_div_sel_out
);
	logic [17:0] stay;
	// cycles spent in the settling state
	always_ff @(posedge mclk_in) begin
		if (rst_in || mode_out != 8'h80)
			stay <= '0;
		else
			stay <= stay + 18'd1;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	chk_settle_len: assert property (
		mode_out != 8'h80 && $past(mode_out) == 8'h80 |-> stay >= 8192 / SETTLE_SCALE)
		else $error("settling wait too short");
	chk_settle_hold: assert property (mode_out == 8'h80 |-> !cpu_run_out)
		else $error("cpu ran while settling");
	chk_standby_wake: assert property (
		mode_out == 8'h20 && wake_in |=> mode_out == 8'h80)
		else $error("standby exit skipped settling");
	chk_watch_exit: assert property (
		mode_out == 8'h40 && wake_in |=> mode_out inside {8'h80, 8'h04})
		else $error("bad watch exit");
	chk_sleep_exit: assert property (
		mode_out == 8'h08 && wake_in |=> mode_out inside {8'h01, 8'h02})
		else $error("bad sleep exit");
	chk_subclock_sel: assert property (
		use_subclock_out == (mode_out inside {8'h04, 8'h10}))
		else $error("subclock select wrong");
	chk_sub_div_lock: assert property (
		mode_out == 8'h04 && $past(mode_out) == 8'h04 |-> $stable(sub_div_sel_out))
		else $error("subactive divider changed");
	chk_noise_gap: assert property ($rose(noise_tick_out) |=> !noise_tick_out [*3])
		else $error("noise tick too fast");
	chk_med_gap: assert property ($rose(med_tick_out) |=> !med_tick_out [*8])
		else $error("medium tick too fast");
endmodule // power_down_ctrl_sva
bind power_down_ctrl power_down_ctrl_sva #(.SETTLE_SCALE(SETTLE_SCALE)) u_sva (
	.mclk_in(mclk_in),
	.rst_in(rst_in),
	.wake_in(wake_in),
	.mode_out(mode_out),
	.cpu_run_out(cpu_run_out),
	.use_subclock_out(use_subclock_out),
	.med_tick_out(med_tick_out),
	.noise_tick_out(noise_tick_out),
	.sub_div_sel_out(sub_div_sel_out)
);
`default_nettype wire

// file: verification/cpu_core_model.sv
// cpu core stand-in issuing sleep and interrupt pulses
`default_nettype none
module cpu_core_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic go_sleep_in,
	input wire logic go_wake_in,
	input wire logic cpu_run_in,
	output logic sleep_out,
	output logic wake_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// a halted core runs no sleep, a running one needs no wake
	always_ff @(posedge mclk_in) begin
		sleep_out <= !rst_in && go_sleep_in && cpu_run_in;
		wake_out <= !rst_in && go_wake_in && !cpu_run_in;
	end
endmodule // cpu_core_model
`default_nettype wire

// file: verification/tb_power_down_ctrl.sv
// testbench for the power-down mode controller
`include "power_down_defines.svh"
`default_nettype none
module tb_power_down_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] RA = `PDM_ADDR_CTRL_A;
	localparam logic [11:0] RB = `PDM_ADDR_CTRL_B;
	logic mclk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, sleep_in, wake_in, go_s = 0, go_w = 0, tbit = 0;
	logic [7:0] mode_out;
	logic cpu_run_out;
	logic osc_run, use_sub, med_tick, noise_tick;
	logic [1:0] sdiv;
	int bad_count = 0, total_checks = 0, cyc = 0, n = 0;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
$display("[FAIL] %0t got %h want %h", $time, a, b); end end
	always #25 mclk_in = ~mclk_in;
	power_down_ctrl #(.SETTLE_SCALE(1024)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_in(sleep_in),
		.wake_in(wake_in), .timer_a_clock_mode_bit_in(tbit), .mode_out(mode_out),
		.cpu_run_out(cpu_run_out), .osc_run_out(osc_run), .use_subclock_out(use_sub),
		.med_tick_out(med_tick), .noise_tick_out(noise_tick), .sub_div_sel_out(sdiv));
	cpu_core_model u_cpu (.mclk_in(mclk_in), .rst_in(rst_in), .go_sleep_in(go_s),
		.go_wake_in(go_w), .cpu_run_in(cpu_run_out), .sleep_out(sleep_in),
		.wake_out(wake_in));
	task automatic end_of_test();
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk_in) penable <= 1;
		@(posedge mclk_in);
		while (pready !== 1'b1) @(posedge mclk_in);
		err = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge mclk_in);
	endtask
	// clocks from one tick to the next, medium (m=1) or noise filter (m=0)
	task automatic gap(input logic m, input int e);
		int k;
		k = 0;
		@(posedge mclk_in);
		while (!(m ? med_tick : noise_tick)) @(posedge mclk_in);
		@(posedge mclk_in);
		k = 1;
		while (!(m ? med_tick : noise_tick) && k < 300) begin
			@(posedge mclk_in);
			k++;
		end
		`CHK(k, e)
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		apb(0, a, 8'h00);
		`CHK(rd, {24'h0, e})
	endtask
	// sleep or wake request, then the mode reached after any settling
	task automatic ev(input logic s, input logic [7:0] e);
		if (s) go_s <= 1;
		else go_w <= 1;
		@(posedge mclk_in) begin go_s <= 0; go_w <= 0; end
		repeat (2) @(posedge mclk_in);
		n = 0;
		while (mode_out === 8'h80 && n < 200) begin @(posedge mclk_in); n++; end
		`CHK(mode_out, e)
		`CHK(cpu_run_out, (e inside {8'h01, 8'h02, 8'h04}))
		`CHK(osc_run, !(e inside {8'h04, 8'h10, 8'h20, 8'h40}))
		`CHK(use_sub, (e inside {8'h04, 8'h10}))
	endtask
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_in <= 0;
		rdc(RA, 8'h07);
		rdc(RB, 8'hE0);
		gap(1, 128);
		gap(0, 16);
		wr(RA, 8'h00);
		rdc(RA, 8'h04);
		gap(1, 16);
		wr(RB, 8'h1F);
		rdc(RB, 8'hFF);
		gap(0, 4);
		`CHK(sdiv, 2'b10)
		apb(0, 12'h010, 8'h00);
		`CHK(({err, rd}), 33'h1_0000_0000)
		ev(1, 8'h02);
		wr(RB, 8'h1B);
		ev(1, 8'h01);
		wr(RA, 8'h88);
		tbit <= 1;
		ev(1, 8'h04);
		wr(RB, 8'h1A);
		rdc(RB, 8'hFB);
		`CHK(sdiv, 2'b10)
		wr(RA, 8'h80);
		ev(1, 8'h01);
		wr(RB, 8'h01);
		`CHK(sdiv, 2'b01)
		tbit <= 0;
		ev(1, 8'h20);
		ev(0, 8'h01);
		`CHK((n inside {[7:10]}), 1'b1)
		wr(RA, 8'hC0);
		ev(1, 8'h20);
		ev(0, 8'h01);
		`CHK((n inside {[127:130]}), 1'b1)
		wr(RA, 8'h80);
		wr(RB, 8'h04);
		`CHK(sdiv, 2'b00)
		tbit <= 1;
		ev(1, 8'h40);
		ev(0, 8'h02);
		wr(RB, 8'h00);
		ev(1, 8'h40);
		ev(0, 8'h01);
		wr(RA, 8'h00);
		wr(RB, 8'h04);
		ev(1, 8'h08);
		ev(0, 8'h02);
		wr(RB, 8'h00);
		ev(1, 8'h08);
		ev(0, 8'h01);
		wr(RA, 8'h88);
		ev(1, 8'h40);
		ev(0, 8'h04);
		wr(RA, 8'h08);
		ev(1, 8'h10);
		ev(0, 8'h04);
		end_of_test();
	end
endmodule // tb_power_down_ctrl
`default_nettype wire
